/* File: gcrc_code_map.v */
// combinational 4b-5b code map, both directions
// code bit 4 is the first bit on the line, bit 0 the last
`timescale 1ns/1ns
`include "gcrc_consts.vh"

module gcrc_code_map
(
    // data to code
    input wire [3:0] data_in,
    output reg [4:0] code_out,
    // code to data
    input wire [4:0] code_in,
    output reg [3:0] data_out,
    output reg code_valid,
    output wire code_sync
);

    // every word starts and ends with at most one zero and holds no 000
    always @*
    begin
        case (data_in)
            4'h0: code_out = 5'h19;
            4'h1: code_out = 5'h1b;
            4'h2: code_out = 5'h12;
            4'h3: code_out = 5'h13;
            4'h4: code_out = 5'h1d;
            4'h5: code_out = 5'h15;
            4'h6: code_out = 5'h16;
            4'h7: code_out = 5'h17;
            4'h8: code_out = 5'h1a;
            4'h9: code_out = 5'h09;
            4'ha: code_out = 5'h0a;
            4'hb: code_out = 5'h0b;
            4'hc: code_out = 5'h1e;
            4'hd: code_out = 5'h0d;
            4'he: code_out = 5'h0e;
            4'hf: code_out = 5'h0f;
            default: code_out = 5'h19;
        endcase
    end

    // inverse map; 11111 is never data
    always @*
    begin
        code_valid = 1'b1;
        case (code_in)
            5'h19: data_out = 4'h0;
            5'h1b: data_out = 4'h1;
            5'h12: data_out = 4'h2;
            5'h13: data_out = 4'h3;
            5'h1d: data_out = 4'h4;
            5'h15: data_out = 4'h5;
            5'h16: data_out = 4'h6;
            5'h17: data_out = 4'h7;
            5'h1a: data_out = 4'h8;
            5'h09: data_out = 4'h9;
            5'h0a: data_out = 4'ha;
            5'h0b: data_out = 4'hb;
            5'h1e: data_out = 4'hc;
            5'h0d: data_out = 4'hd;
            5'h0e: data_out = 4'he;
            5'h0f: data_out = 4'hf;
            default:
            begin
                // anything else, sync mark included, is no data word
                data_out = 4'h0;
                code_valid = 1'b0;
            end
        endcase
    end

    assign code_sync = (code_in == `GCRC_SYNC_MARK);

endmodule // gcrc_code_map

/* File: gcrc_codec.v */
// 4b-5b group code encoder/decoder with a five-bit shift register
// assumes all control and serial pins are synchronous to sys_clk
`timescale 1ns/1ns
`include "gcrc_consts.vh"

module gcrc_codec
(
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // controller side
    input wire enable_n,
    input wire mode_sel_1,
    input wire mode_sel_0,
    input wire [3:0] par_data_in,
    input wire flag_clear_n,
    // tape side
    input wire serial_in_bit,
    // five-bit register, top to bottom
    output reg reg_bit_top,
    output reg reg_bit_2,
    output reg reg_bit_1,
    output reg reg_bit_0,
    output reg serial_out_bit,
    // status pins
    output reg sync_mark_seen_n,
    output reg bad_code_flag_n,
    // register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // interrupt
    output reg irq
);

    wire [1:0] mode;
    wire active;
    wire [4:0] shift_now;
    wire [4:0] code_from_data;
    wire [3:0] data_from_code;
    wire code_valid;
    wire code_sync;
    reg [4:0] next_shift;
    reg bad_flag;
    reg next_bad_flag;
    wire bad_set;
    wire bad_clear;
    reg [3:0] events;
    reg [3:0] next_events;
    reg [3:0] irq_en;
    reg [3:0] next_irq_en;
    reg [3:0] event_hit;
    wire [3:0] event_clear;
    reg [7:0] bad_count;
    reg [7:0] word_count;
    reg [7:0] next_rdata;

    assign mode = {mode_sel_1, mode_sel_0};
    assign active = ~enable_n;

    // register word as a line-order code: reg_bit_top holds bit 4
    assign shift_now = {reg_bit_top, reg_bit_2, reg_bit_1, reg_bit_0, serial_out_bit};

    gcrc_code_map u_map
    (
        .data_in(par_data_in),
        .code_out(code_from_data),
        .code_in(shift_now),
        .data_out(data_from_code),
        .code_valid(code_valid),
        .code_sync(code_sync)
    );

    // next register contents per mode
    always @*
    begin
        next_shift = shift_now;
        if (!active)
        begin
            next_shift = shift_now;
        end
        else
        begin
            case (mode)
                `GCRC_MODE_SHIFT_IN:
                begin
                    // bits move toward the top, new bit enters at the bottom
                    next_shift = {shift_now[3:0], serial_in_bit};
                end
                `GCRC_MODE_DECODE:
                begin
                    // decoded data on top four bits, line keeps flowing below
                    next_shift = {data_from_code, serial_in_bit};
                end
                `GCRC_MODE_ENCODE:
                begin
                    // code lsb at the top, msb at the serial output
                    next_shift = {code_from_data[0], code_from_data[1], code_from_data[2],
                        code_from_data[3], code_from_data[4]};
                end
                `GCRC_MODE_SHIFT_OUT:
                begin
                    // rotate: serial output refills from reg_bit_0, top from output
                    next_shift = {serial_out_bit, shift_now[4:1]};
                end
                default:
                begin
                    next_shift = shift_now;
                end
            endcase
        end
    end

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            reg_bit_top <= 1'b0;
            reg_bit_2 <= 1'b0;
            reg_bit_1 <= 1'b0;
            reg_bit_0 <= 1'b0;
            serial_out_bit <= 1'b0;
        end
        else
        begin
            reg_bit_top <= next_shift[4];
            reg_bit_2 <= next_shift[3];
            reg_bit_1 <= next_shift[2];
            reg_bit_0 <= next_shift[1];
            serial_out_bit <= next_shift[0];
        end
    end

    // sync pin registered from the next contents so it tracks the register exactly
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sync_mark_seen_n <= 1'b1;
        end
        else
        begin
            sync_mark_seen_n <= ~(&next_shift);
        end
    end

    // bad code flag: active high inside, inverted at the pin
    assign bad_set = active && (mode == `GCRC_MODE_DECODE) && !code_valid && !code_sync;
    assign bad_clear = ~flag_clear_n;

    always @*
    begin
        next_bad_flag = bad_flag;
        if (bad_clear)
        begin
            next_bad_flag = 1'b0;
        end
        // a new bad word in the clearing cycle is not lost
        if (bad_set)
        begin
            next_bad_flag = 1'b1;
        end
    end

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            bad_flag <= 1'b0;
            bad_code_flag_n <= 1'b1;
        end
        else
        begin
            bad_flag <= next_bad_flag;
            bad_code_flag_n <= ~next_bad_flag;
        end
    end

    // events for the sticky status register
    always @*
    begin
        event_hit = 4'h0;
        event_hit[`GCRC_EV_BAD_CODE] = bad_set;
        event_hit[`GCRC_EV_SYNC_MARK] = (&next_shift) && !(&shift_now);
        event_hit[`GCRC_EV_DECODED] = active && (mode == `GCRC_MODE_DECODE) && code_valid;
        event_hit[`GCRC_EV_ENCODED] = active && (mode == `GCRC_MODE_ENCODE);
    end

    assign event_clear = (reg_wr && (reg_addr == `GCRC_ADDR_CLEAR)) ? reg_wdata[3:0] : 4'h0;

    // set wins over a clear landing in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < `GCRC_EV_W; gi = gi + 1)
        begin : g_event
            always @*
            begin
                next_events[gi] = event_hit[gi] | (events[gi] & ~event_clear[gi]);
            end
        end
    endgenerate

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            events <= `GCRC_RST_EVENTS;
            irq <= 1'b0;
        end
        else
        begin
            events <= next_events;
            // next enable too, so a write to the enable shows on irq at once
            irq <= |(next_events & next_irq_en);
        end
    end

    // interrupt enable
    always @*
    begin
        next_irq_en = irq_en;
        if (reg_wr && (reg_addr == `GCRC_ADDR_IRQ_EN))
        begin
            next_irq_en = reg_wdata[3:0];
        end
    end

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            irq_en <= `GCRC_RST_IRQ_EN;
        end
        else
        begin
            irq_en <= next_irq_en;
        end
    end

    // saturating word counters; writing either one clears it unless it counts in the same cycle
    // saturation, not wrap, so a flood of bad words never reads back as a few
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            bad_count <= `GCRC_RST_COUNT;
        end
        else if (bad_set && (bad_count != `GCRC_COUNT_MAX))
        begin
            bad_count <= bad_count + 8'h01;
        end
        else if (reg_wr && (reg_addr == `GCRC_ADDR_BAD_COUNT))
        begin
            bad_count <= `GCRC_RST_COUNT;
        end
    end

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            word_count <= `GCRC_RST_COUNT;
        end
        else if (event_hit[`GCRC_EV_DECODED] && (word_count != `GCRC_COUNT_MAX))
        begin
            word_count <= word_count + 8'h01;
        end
        else if (reg_wr && (reg_addr == `GCRC_ADDR_WORD_COUNT))
        begin
            word_count <= `GCRC_RST_COUNT;
        end
    end

    // read mux; unmapped and write-only addresses read zero
    always @*
    begin
        next_rdata = 8'h00;
        case (reg_addr)
            `GCRC_ADDR_STATUS: next_rdata = {4'h0, events};
            `GCRC_ADDR_IRQ_EN: next_rdata = {4'h0, irq_en};
            `GCRC_ADDR_LIVE: next_rdata = {2'h0, bad_flag, shift_now};
            `GCRC_ADDR_BAD_COUNT: next_rdata = bad_count;
            `GCRC_ADDR_WORD_COUNT: next_rdata = word_count;
            default: next_rdata = 8'h00;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            reg_rdata <= next_rdata;
        end
        else
        begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // gcrc_codec

/* File: gcrc_codec_props.sv */
// checker for the codec pins: register modes, code map and status flags
// assumes one clock sys_clk and rst asynchronous, active high
`timescale 1ns/1ns
module gcrc_codec_chk
(
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // controls
    input wire enable_n,
    input wire mode_sel_1,
    input wire mode_sel_0,
    input wire [3:0] par_data_in,
    input wire flag_clear_n,
    input wire serial_in_bit,
    // register and status
    input wire reg_bit_top,
    input wire reg_bit_2,
    input wire reg_bit_1,
    input wire reg_bit_0,
    input wire serial_out_bit,
    input wire sync_mark_seen_n,
    input wire bad_code_flag_n
);
    // code of data n at bits 5n+4..5n, first line bit highest
    localparam [79:0] CODES = {5'h0f, 5'h0e, 5'h0d, 5'h1e, 5'h0b, 5'h0a, 5'h09, 5'h1a,
        5'h17, 5'h16, 5'h15, 5'h1d, 5'h13, 5'h12, 5'h1b, 5'h19};
    function automatic [4:0] lookup(input [4:0] c);
        integer n;
        begin
            lookup = 5'h00;
            for (n = 0; n < 16; n = n + 1)
                if (CODES[n*5 +: 5] == c)
                    lookup = {1'b1, n[3:0]};
        end
    endfunction
    wire [4:0] word = {reg_bit_top, reg_bit_2, reg_bit_1, reg_bit_0, serial_out_bit};
    wire [4:0] rev = {serial_out_bit, reg_bit_0, reg_bit_1, reg_bit_2, reg_bit_top};
    wire [1:0] mode = {mode_sel_1, mode_sel_0};
    wire dec = !enable_n && mode == 2'h2;
    wire [4:0] hit = lookup(word);
    wire [3:0] hit_data = hit[3:0];
    wire bad = dec && !hit[4] && word != 5'h1f;
    wire [4:0] shin = {word[3:0], serial_in_bit};
    wire [4:0] shout = {serial_out_bit, word[4:1]};
    wire [4:0] enc_code = CODES[par_data_in*5 +: 5];
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    hold_reg_a: assert property (enable_n |=> $stable(word))
        else $error("register moved while disabled");
    shift_in_a: assert property (!enable_n && mode == 2'h0 |=> word == $past(shin))
        else $error("shift in wrong");
    shift_out_a: assert property (!enable_n && mode == 2'h1 |=> word == $past(shout))
        else $error("shift out wrong");
    encode_word_a: assert property (!enable_n && mode == 2'h3 |=> rev == $past(enc_code))
        else $error("encode wrong");
    decode_data_a: assert property (dec && hit[4] |=> word[4:1] == $past(hit_data))
        else $error("decode wrong");
    decode_sin_a: assert property (dec |=> serial_out_bit == $past(serial_in_bit))
        else $error("serial bit lost in decode");
    sync_pin_a: assert property (sync_mark_seen_n == !(&word))
        else $error("sync pin wrong");
    bad_set_a: assert property (bad |=> !bad_code_flag_n)
        else $error("bad word not flagged");
    bad_source_a: assert property ($fell(bad_code_flag_n) |-> $past(bad))
        else $error("flag set outside decode");
    bad_hold_a: assert property (!bad_code_flag_n && flag_clear_n |=> !bad_code_flag_n)
        else $error("flag dropped");
    bad_clear_a: assert property (!flag_clear_n && !bad |=> bad_code_flag_n)
        else $error("flag not cleared");
    cover property (bad);
    cover property (dec && hit[4]);
    cover property (!sync_mark_seen_n);
endmodule // gcrc_codec_chk

bind gcrc_codec gcrc_codec_chk u_chk (.*);

/* File: gcrc_codec_tb.sv */
// bench for the codec: all codes out and back, hold, reset, sync, bad flag, interrupt
// assumes the tape model drives serial_in_bit
`timescale 1ns/1ns
`include "gcrc_consts.vh"
`define CHK(g, e) \
    begin \
        compares = compares + 1; \
        if ((g) !== (e)) \
        begin \
            mismatches = mismatches + 1; \
            $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end
module gcrc_codec_tb;
    reg sys_clk = 1'b0;
    reg rst = 1'b1;
    reg enable_n = 1'b1;
    reg mode_sel_1 = 1'b0;
    reg mode_sel_0 = 1'b0;
    reg [3:0] par_data_in = 4'h0;
    reg flag_clear_n = 1'b1;
    reg [3:0] reg_addr = 4'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg send = 1'b0;
    reg [4:0] word = 5'h00;
    reg listen = 1'b0;
    wire serial_in_bit, reg_bit_top, reg_bit_2, reg_bit_1, reg_bit_0, serial_out_bit;
    wire sync_mark_seen_n, bad_code_flag_n, irq;
    wire [7:0] reg_rdata;
    wire [4:0] heard;
    wire [2:0] zero_max;
    wire [4:0] bits = {reg_bit_top, reg_bit_2, reg_bit_1, reg_bit_0, serial_out_bit};
    // row n: data n in, its code out
    localparam [79:0] ROWS = {5'h0f, 5'h0e, 5'h0d, 5'h1e, 5'h0b, 5'h0a, 5'h09, 5'h1a,
        5'h17, 5'h16, 5'h15, 5'h1d, 5'h13, 5'h12, 5'h1b, 5'h19};
    integer mismatches = 0;
    integer compares = 0;
    integer cycles = 0;
    integer i;
    reg [7:0] r;
    reg [4:0] code;
    reg [4:0] got;
    gcrc_codec u_dut (.*);
    gcrc_tape_model u_tape (.*);
    initial
    begin
        forever #4 sys_clk = ~sys_clk;
    end
    task close_out;
        begin
            $display("compares=%0d mismatches=%0d", compares, mismatches);
            if (mismatches == 0 && compares > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    always @(posedge sys_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 3000)
        begin
            mismatches = mismatches + 1;
            close_out;
        end
    end
    task step(input en_n, input [1:0] mode);
        begin
            @(posedge sys_clk);
            enable_n <= en_n;
            {mode_sel_1, mode_sel_0} <= mode;
            #1;
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge sys_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge sys_clk);
            reg_wr <= 1'b0;
            #1;
        end
    endtask
    task rd(input [3:0] a, output [7:0] d);
        begin
            @(posedge sys_clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge sys_clk);
            reg_rd <= 1'b0;
            #1;
            d = reg_rdata;
        end
    endtask
    // encode then four shifts; loaded word returned first line bit highest
    task xmit(input [3:0] d, output [4:0] loaded);
        begin
            @(posedge sys_clk);
            par_data_in <= d;
            step(1'b0, `GCRC_MODE_ENCODE);
            step(1'b0, `GCRC_MODE_SHIFT_OUT);
            // encode has landed; the line carries code bit 4 until the next edge
            loaded = {serial_out_bit, reg_bit_0, reg_bit_1, reg_bit_2, reg_bit_top};
            listen <= 1'b1;
            repeat (3) step(1'b0, `GCRC_MODE_SHIFT_OUT);
            step(1'b1, 2'h0);
            @(posedge sys_clk);
            listen <= 1'b0;
            #1;
        end
    endtask
    // tape plays c; five shift-in edges, then hold for decode
    task recv(input [4:0] c);
        begin
            @(posedge sys_clk);
            send <= 1'b1;
            word <= c;
            step(1'b0, `GCRC_MODE_SHIFT_IN);
            send <= 1'b0;
            repeat (4) step(1'b0, `GCRC_MODE_SHIFT_IN);
            step(1'b1, 2'h0);
        end
    endtask
    task decode;
        begin
            step(1'b0, `GCRC_MODE_DECODE);
            step(1'b1, 2'h0);
        end
    endtask
    initial
    begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        for (i = 0; i < 16; i = i + 1)
        begin
            code = ROWS[i*5 +: 5];
            xmit(i[3:0], got);
            `CHK(got, code)
            `CHK(heard, code)
            `CHK(sync_mark_seen_n, 1'b1)
            recv(code);
            decode;
            // idle line toggles, so the bit caught at decode is c[0]
            `CHK(bits, {i[3:0], code[0]})
            `CHK(bad_code_flag_n, 1'b1)
        end
        `CHK(zero_max, 3'h2)
        $display("rows done");
        for (i = 0; i < 5; i = i + 1)
        begin
            step(1'b1, i[1:0]);
            `CHK(bits, 5'h1f)
        end
        `CHK(sync_mark_seen_n, 1'b0)
        rd(`GCRC_ADDR_WORD_COUNT, r);
        `CHK(r, 8'h10)
        rd(`GCRC_ADDR_STATUS, r);
        `CHK(r, 8'h0e)
        $display("hold done");
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK({bits, sync_mark_seen_n, bad_code_flag_n, irq}, 8'h06)
        @(posedge sys_clk);
        rst <= 1'b0;
        rd(`GCRC_ADDR_IRQ_EN, r);
        `CHK(r, 8'h00)
        $display("reset done");
        recv(5'h1f);
        `CHK(sync_mark_seen_n, 1'b0)
        decode;
        `CHK(bad_code_flag_n, 1'b1)
        rd(`GCRC_ADDR_STATUS, r);
        `CHK(r, 8'h02)
        rd(`GCRC_ADDR_LIVE, r);
        `CHK(r, 8'h01)
        $display("sync done");
        wr(`GCRC_ADDR_CLEAR, 8'h0f);
        wr(`GCRC_ADDR_BAD_COUNT, 8'h00);
        wr(`GCRC_ADDR_IRQ_EN, 8'h01);
        recv(5'h00);
        step(1'b0, `GCRC_MODE_SHIFT_OUT);
        step(1'b1, 2'h0);
        `CHK(bad_code_flag_n, 1'b1)
        `CHK(irq, 1'b0)
        decode;
        `CHK(bad_code_flag_n, 1'b0)
        `CHK(irq, 1'b1)
        repeat (3) step(1'b1, 2'h0);
        `CHK(bad_code_flag_n, 1'b0)
        rd(`GCRC_ADDR_STATUS, r);
        `CHK(r, 8'h01)
        rd(`GCRC_ADDR_BAD_COUNT, r);
        `CHK(r, 8'h01)
        wr(`GCRC_ADDR_IRQ_EN, 8'h00);
        step(1'b1, 2'h0);
        `CHK(irq, 1'b0)
        wr(`GCRC_ADDR_IRQ_EN, 8'h01);
        step(1'b1, 2'h0);
        `CHK(irq, 1'b1)
        wr(`GCRC_ADDR_CLEAR, 8'h01);
        step(1'b1, 2'h0);
        `CHK(irq, 1'b0)
        rd(4'hf, r);
        `CHK(r, 8'h00)
        @(posedge sys_clk);
        flag_clear_n <= 1'b0;
        @(posedge sys_clk);
        flag_clear_n <= 1'b1;
        #1;
        `CHK(bad_code_flag_n, 1'b1)
        $display("flag and irq done");
        close_out;
    end
endmodule // gcrc_codec_tb

/* File: gcrc_consts.vh */
// constants for the 4b-5b group code encoder/decoder
// assumes a single 125 MHz clock and an 8-bit plain register port
`ifndef GCRC_CONSTS_VH
`define GCRC_CONSTS_VH

// clock
`define GCRC_CLK_PERIOD_NS 8

// mode codes, {mode_sel_1, mode_sel_0}
`define GCRC_MODE_SHIFT_IN 2'h0
`define GCRC_MODE_SHIFT_OUT 2'h1
`define GCRC_MODE_DECODE 2'h2
`define GCRC_MODE_ENCODE 2'h3

// word sizes and sync mark
`define GCRC_CODE_W 5
`define GCRC_DATA_W 4
`define GCRC_SYNC_MARK 5'h1f

// register port
`define GCRC_ADDR_W 4
`define GCRC_REG_W 8
`define GCRC_ADDR_STATUS 4'h0
`define GCRC_ADDR_CLEAR 4'h1
`define GCRC_ADDR_IRQ_EN 4'h2
`define GCRC_ADDR_LIVE 4'h3
`define GCRC_ADDR_BAD_COUNT 4'h4
`define GCRC_ADDR_WORD_COUNT 4'h5

// event bits of status, clear and enable registers
`define GCRC_EV_BAD_CODE 0
`define GCRC_EV_SYNC_MARK 1
`define GCRC_EV_DECODED 2
`define GCRC_EV_ENCODED 3
`define GCRC_EV_W 4

// reset values and counter limit
`define GCRC_RST_SHIFT 5'h00
`define GCRC_RST_EVENTS 4'h0
`define GCRC_RST_IRQ_EN 4'h0
`define GCRC_RST_COUNT 8'h00
`define GCRC_COUNT_MAX 8'hff

`endif

/* File: gcrc_tape_model.sv */
// tape drive stand-in: plays a code word onto the read line, listens to the write line
// assumes send is a one-cycle pulse synchronous to sys_clk
`timescale 1ns/1ns
module gcrc_tape_model
(
    // clock
    input wire sys_clk,
    // bench control
    input wire send,
    input wire [4:0] word,
    input wire listen,
    // line
    input wire serial_out_bit,
    output reg serial_in_bit = 1'b0,
    output reg [4:0] heard = 5'h00,
    output reg [2:0] zero_max = 3'h0
);
    reg [3:0] rest = 4'h0;
    reg [2:0] left = 3'h0;
    reg [2:0] zero_run = 3'h0;
    always @(posedge sys_clk)
    begin
        if (send)
        begin
            serial_in_bit <= word[4];
            rest <= word[3:0];
            left <= 3'h4;
        end
        else if (left != 3'h0)
        begin
            serial_in_bit <= rest[3];
            rest <= {rest[2:0], 1'b0};
            left <= left - 3'h1;
        end
        else
            serial_in_bit <= ~serial_in_bit; // idle line must not look like a held bit
        if (listen)
        begin
            heard <= {heard[3:0], serial_out_bit};
            zero_run <= serial_out_bit ? 3'h0 : zero_run + 3'h1;
            if (!serial_out_bit && zero_run + 3'h1 > zero_max)
                zero_max <= zero_run + 3'h1;
        end
    end
endmodule // gcrc_tape_model
